// ==== core/ifsb_ahb_port.sv ====
// AHB-Lite address-phase decoder for the flag bank.
// Assumes the slave never inserts wait states, so every data phase lasts one cycle.
`timescale 1ns/1ps
`include "ifsb_regs.svh"

module ifsb_ahb_port (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    output logic o_rd_take,
    output logic o_wr_pend
);

    logic wr_q;
    logic wr_d;
    logic xfer_valid;
    logic addr_hit;

    function automatic logic word_hit(input logic [31:0] addr);
        word_hit = (addr[31:2] == 30'(`IFSB_FLAGS_OFFSET >> 2));
    endfunction : word_hit

    // Bit 1 of htrans is high for NONSEQ and SEQ; IDLE and BUSY carry no transfer.
    assign xfer_valid = i_hsel & i_hready & i_htrans[1];
    assign addr_hit = word_hit(i_haddr);
    assign o_rd_take = xfer_valid & ~i_hwrite & addr_hit;
    assign wr_d = xfer_valid & i_hwrite & addr_hit;
    assign o_wr_pend = wr_q;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_q <= 1'b0;
        end
        else
        begin
            wr_q <= wr_d;
        end
    end

endmodule : ifsb_ahb_port

// ==== core/ifsb_bank.sv ====
// Interrupt flag status bank: one 16-bit word of sticky request flags behind AHB-Lite.
// Assumes the request inputs come from logic on i_clk and are high for each cycle of a request.
//
// How it works
// - Bit 14 is the real-time clock/calendar flag, set by its request.
// - Bit 6 is the external line 4 flag, set by its request.
// - Bit 5 is the external line 3 flag, set by its request.
// - Bit 2 is the second I2C port master event flag, set by request.
// - Bit 1 is the second I2C port slave event flag, set by request.
// - Bits 15, 13-7, 4-3 and 0 read zero and ignore writes.
// - Implemented flags are set by hardware and read and written by software.
// - One means the request has occurred, zero means it has not.
`timescale 1ns/1ps
`include "ifsb_regs.svh"

module ifsb_bank (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic [2:0] i_hsize,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic [31:0] i_hwdata,
    input wire logic i_rtcc_req,
    input wire logic i_ext_line4_req,
    input wire logic i_ext_line3_req,
    input wire logic i_i2c_port2_master_req,
    input wire logic i_i2c_port2_slave_req,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [15:0] o_flags,
    output logic o_rtcc_event_flag,
    output logic o_ext_line4_event_flag,
    output logic o_ext_line3_event_flag,
    output logic o_i2c_port2_master_event_flag,
    output logic o_i2c_port2_slave_event_flag
);

    ifsb_pkg::ifsb_flags_t flags_q;
    ifsb_pkg::ifsb_flags_t flags_d;
    ifsb_pkg::ifsb_flags_t set_vec;
    ifsb_pkg::ifsb_flags_t wr_val;
    ifsb_pkg::ifsb_word_t hrdata_q;
    ifsb_pkg::ifsb_word_t hrdata_d;
    logic hreadyout_q;
    logic hresp_q;
    logic rd_take;
    logic wr_pend;

    // Places each request at its flag position; positions outside the mask stay zero.
    function automatic ifsb_pkg::ifsb_flags_t place_requests(
        input logic rtcc,
        input logic ext4,
        input logic ext3,
        input logic i2c_m,
        input logic i2c_s
    );
        ifsb_pkg::ifsb_flags_t v;
        v = `IFSB_FLAGS_RESET;
        v[`IFSB_RTCC_BIT] = rtcc;
        v[`IFSB_EXT4_BIT] = ext4;
        v[`IFSB_EXT3_BIT] = ext3;
        v[`IFSB_I2C2_MASTER_BIT] = i2c_m;
        v[`IFSB_I2C2_SLAVE_BIT] = i2c_s;
        place_requests = v;
    endfunction : place_requests

    ifsb_ahb_port u_port (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_hsel(i_hsel),
        .i_haddr(i_haddr),
        .i_htrans(i_htrans),
        .i_hwrite(i_hwrite),
        .i_hready(i_hready),
        .o_rd_take(rd_take),
        .o_wr_pend(wr_pend)
    );

    assign set_vec = place_requests(
        i_rtcc_req,
        i_ext_line4_req,
        i_ext_line3_req,
        i_i2c_port2_master_req,
        i_i2c_port2_slave_req
    );

    // Unimplemented positions are masked off the write data so they can never hold a one.
    assign wr_val = i_hwdata[15:0] & `IFSB_FLAGS_MASK;

    // A set in the same cycle as a software write of zero wins, so no request is lost.
    assign flags_d = ((wr_pend ? wr_val : flags_q) | set_vec) & `IFSB_FLAGS_MASK;

    // Reads sample the next value so a write or set landing on the same edge is seen at once.
    assign hrdata_d = rd_take ? {16'h0000, flags_d} : 32'h0000_0000;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            flags_q <= `IFSB_FLAGS_RESET;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q <= `IFSB_HRESP_OKAY;
        end
        else
        begin
            hrdata_q <= hrdata_d;
            hreadyout_q <= 1'b1;
            hresp_q <= `IFSB_HRESP_OKAY;
        end
    end

    assign o_hrdata = hrdata_q;
    assign o_hreadyout = hreadyout_q;
    assign o_hresp = hresp_q;
    assign o_flags = flags_q;
    assign o_rtcc_event_flag = flags_q[`IFSB_RTCC_BIT];
    assign o_ext_line4_event_flag = flags_q[`IFSB_EXT4_BIT];
    assign o_ext_line3_event_flag = flags_q[`IFSB_EXT3_BIT];
    assign o_i2c_port2_master_event_flag = flags_q[`IFSB_I2C2_MASTER_BIT];
    assign o_i2c_port2_slave_event_flag = flags_q[`IFSB_I2C2_SLAVE_BIT];

    // Each request shows in its flag one edge later, whatever software writes meanwhile.
    rtcc_flag_set_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_rtcc_req |=> o_rtcc_event_flag && o_flags[14]
    )
    else
        $error("Clock/calendar request did not set bit 14.");

    ext4_flag_set_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_ext_line4_req |=> o_flags[6] ##1 (o_flags[6] || ($past(wr_pend) && !$past(i_hwdata[6])))
    )
    else
        $error("Line 4 request did not set bit 6 or it dropped without a write.");

    ext3_flag_set_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_ext_line3_req |=> o_flags[5] && o_ext_line3_event_flag
    )
    else
        $error("Line 3 request did not set bit 5.");

    i2c_master_set_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_i2c_port2_master_req |=> o_flags[2] && o_i2c_port2_master_event_flag
    )
    else
        $error("I2C master request did not set bit 2.");

    i2c_slave_set_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_i2c_port2_slave_req |=> o_flags[1] && !(o_flags[2] && !$past(o_flags[2])
            && !$past(i_i2c_port2_master_req) && !$past(wr_pend))
    )
    else
        $error("I2C slave request did not set bit 1, or bit 2 rose with no cause.");

    unused_bits_zero_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (o_flags & ~`IFSB_FLAGS_MASK) == 16'h0000 && o_hrdata[31:16] == 16'h0000
            && (o_hrdata[15:0] & ~`IFSB_FLAGS_MASK) == 16'h0000
    )
    else
        $error("An unimplemented bit reads as one.");

    write_lands_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        wr_pend && set_vec == 16'h0000 |=> o_flags == ($past(i_hwdata[15:0]) & `IFSB_FLAGS_MASK)
    )
    else
        $error("Software write did not land in the flag word.");

    read_returns_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        rd_take |=> o_hrdata == {16'h0000, o_flags} && o_hreadyout && o_hresp == `IFSB_HRESP_OKAY
    )
    else
        $error("Read data does not match the flag word.");

    flag_holds_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        !wr_pend && set_vec == 16'h0000 |=> $stable(o_flags)
    )
    else
        $error("Flag word changed with no request and no write.");

    flag_only_rises_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_rtcc_event_flag) |-> $past(i_rtcc_req) || ($past(wr_pend) && $past(i_hwdata[14]))
    )
    else
        $error("Clock/calendar flag set without a request or write.");

    set_beats_clear_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        wr_pend && i_hwdata[15:0] == 16'h0000 && i_ext_line3_req |=> o_ext_line3_event_flag
            && o_flags == $past(set_vec)
    )
    else
        $error("A same-cycle request was lost to a clearing write.");

    idle_read_zero_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        !rd_take |=> o_hrdata == 32'h0000_0000
    )
    else
        $error("Read data drives a value outside a read data phase.");

    // A flag may only rise because its source asked or software wrote a one to it.
    ext4_only_rises_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_ext_line4_event_flag) |-> $past(i_ext_line4_req)
            || ($past(wr_pend) && $past(i_hwdata[`IFSB_EXT4_BIT]))
    )
    else
        $error("Line 4 flag set without a request or write.");

    ext3_only_rises_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_ext_line3_event_flag) |-> $past(i_ext_line3_req)
            || ($past(wr_pend) && $past(i_hwdata[`IFSB_EXT3_BIT]))
    )
    else
        $error("Line 3 flag set without a request or write.");

    i2c_master_rises_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_i2c_port2_master_event_flag) |-> $past(i_i2c_port2_master_req)
            || ($past(wr_pend) && $past(i_hwdata[`IFSB_I2C2_MASTER_BIT]))
    )
    else
        $error("I2C master flag set without a request or write.");

    i2c_slave_rises_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_i2c_port2_slave_event_flag) |-> $past(i_i2c_port2_slave_req)
            || ($past(wr_pend) && $past(i_hwdata[`IFSB_I2C2_SLAVE_BIT]))
    )
    else
        $error("I2C slave flag set without a request or write.");

    // Requests only ever add ones, so without a write no flag may fall.
    flags_never_fall_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        !wr_pend |=> ($past(o_flags) & ~o_flags) == 16'h0000
    )
    else
        $error("A flag fell with no software write.");

    set_wins_all_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        wr_pend && set_vec != 16'h0000 |=> (o_flags & $past(set_vec)) == $past(set_vec)
    )
    else
        $error("A request was lost to a same-cycle write.");

    // A written zero clears its flag whenever no request for it arrives on the same edge.
    rtcc_clear_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        wr_pend && !i_hwdata[`IFSB_RTCC_BIT] && !i_rtcc_req |=> !o_rtcc_event_flag
    )
    else
        $error("Writing zero did not clear the clock/calendar flag.");

    ext4_clear_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        wr_pend && !i_hwdata[`IFSB_EXT4_BIT] && !i_ext_line4_req |=> !o_ext_line4_event_flag
    )
    else
        $error("Writing zero did not clear the line 4 flag.");

    ext3_clear_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        wr_pend && !i_hwdata[`IFSB_EXT3_BIT] && !i_ext_line3_req |=> !o_ext_line3_event_flag
    )
    else
        $error("Writing zero did not clear the line 3 flag.");

    i2c_master_clear_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        wr_pend && !i_hwdata[`IFSB_I2C2_MASTER_BIT] && !i_i2c_port2_master_req |=> !o_i2c_port2_master_event_flag
    )
    else
        $error("Writing zero did not clear the I2C master flag.");

    i2c_slave_clear_a : assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        wr_pend && !i_hwdata[`IFSB_I2C2_SLAVE_BIT] && !i_i2c_port2_slave_req |=> !o_i2c_port2_slave_event_flag
    )
    else
        $error("Writing zero did not clear the I2C slave flag.");

endmodule : ifsb_bank

// ==== core/ifsb_pkg.sv ====
// Types shared by the interrupt flag status bank modules.
// Assumes the register map header is compiled alongside.
package ifsb_pkg;

    typedef logic [15:0] ifsb_flags_t;
    typedef logic [31:0] ifsb_word_t;

endpackage : ifsb_pkg

// ==== core/ifsb_regs.svh ====
// Register map constants of the interrupt flag status bank.
// Assumes a 32-bit AHB-Lite bus with one aligned word per register.
`ifndef IFSB_REGS_SVH
`define IFSB_REGS_SVH

`define IFSB_FLAGS_OFFSET 32'h0000_0000
`define IFSB_FLAGS_RESET 16'h0000
`define IFSB_FLAGS_MASK 16'h4066

`define IFSB_RTCC_BIT 14
`define IFSB_EXT4_BIT 6
`define IFSB_EXT3_BIT 5
`define IFSB_I2C2_MASTER_BIT 2
`define IFSB_I2C2_SLAVE_BIT 1

`define IFSB_HRESP_OKAY 1'h0

`endif

// ==== verif/ifsb_bank_tb.sv ====
// Self-checking bench for the flag bank: AHB-Lite master tasks plus a request source model.
// Assumes the bank answers without wait states but still waits on hready for each phase.
`timescale 1ns/1ps
`include "ifsb_regs.svh"

module ifsb_bank_tb;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [4:0] fire = 5'h00;
    logic [31:0] rd;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [15:0] flags;
    logic [4:0] flag_vec;
    logic [4:0] req;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    localparam int POS[5] = '{`IFSB_I2C2_SLAVE_BIT, `IFSB_I2C2_MASTER_BIT, `IFSB_EXT3_BIT, `IFSB_EXT4_BIT,
        `IFSB_RTCC_BIT};

    always #5 i_clk = ~i_clk;

    ifsb_src_model src (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_fire(fire), .o_rtcc_req(req[4]),
        .o_ext_line4_req(req[3]), .o_ext_line3_req(req[2]), .o_i2c_port2_master_req(req[1]),
        .o_i2c_port2_slave_req(req[0]));

    ifsb_bank uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hsize(3'h2), .i_hwrite(hwrite), .i_hready(hready), .i_hwdata(hwdata), .i_rtcc_req(req[4]),
        .i_ext_line4_req(req[3]), .i_ext_line3_req(req[2]), .i_i2c_port2_master_req(req[1]),
        .i_i2c_port2_slave_req(req[0]), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .o_flags(flags), .o_rtcc_event_flag(flag_vec[4]), .o_ext_line4_event_flag(flag_vec[3]),
        .o_ext_line3_event_flag(flag_vec[2]), .o_i2c_port2_master_event_flag(flag_vec[1]),
        .o_i2c_port2_slave_event_flag(flag_vec[0]));

    task stop_test;
        $display("mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task check_word(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : check_word

    // The fire vector rides with the address phase so its request lands on the data-phase edge.
    task ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [4:0] f);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        fire <= f;
        @(posedge i_clk);
        while (hready !== 1'b1) @(posedge i_clk);
        htrans <= 2'h0;
        hwdata <= d;
        fire <= 5'h00;
        @(posedge i_clk);
        while (hready !== 1'b1) @(posedge i_clk);
        rd = hrdata;
        check_word({31'h0, `IFSB_HRESP_OKAY}, {31'h0, hresp});
    endtask : ahb_xfer

    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    initial
    begin
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        ahb_xfer(1'b0, `IFSB_FLAGS_OFFSET, 32'h0, 5'h00);
        check_word({16'h0, `IFSB_FLAGS_RESET}, rd);
        ahb_xfer(1'b1, `IFSB_FLAGS_OFFSET, 32'hffff_ffff, 5'h00);
        ahb_xfer(1'b0, `IFSB_FLAGS_OFFSET, 32'h0, 5'h00);
        check_word(32'h0000_4066, rd);
        check_word({27'h0, 5'h1f}, {27'h0, flag_vec});
        for (int k = 0; k < 5; k++)
        begin
            ahb_xfer(1'b1, `IFSB_FLAGS_OFFSET, 32'h0, 5'h00);
            // The write lands on the edge that ends its data phase, so the flags are looked at one edge later.
            @(posedge i_clk);
            check_word(32'h0, {16'h0, flags});
            fire <= 5'h01 << k;
            @(posedge i_clk);
            fire <= 5'h00;
            @(posedge i_clk);
            @(posedge i_clk);
            check_word(32'h1 << POS[k], {16'h0, flags});
            check_word({27'h0, 5'h01 << k}, {27'h0, flag_vec});
            ahb_xfer(1'b0, `IFSB_FLAGS_OFFSET, 32'h0, 5'h00);
            check_word(32'h1 << POS[k], rd);
        end
        ahb_xfer(1'b1, `IFSB_FLAGS_OFFSET, 32'h0, 5'h1f);
        @(posedge i_clk);
        check_word(32'h0000_4066, {16'h0, flags});
        ahb_xfer(1'b1, 32'h0000_0004, 32'h0, 5'h00);
        ahb_xfer(1'b0, 32'h0000_0004, 32'h0, 5'h00);
        check_word(32'h0, rd);
        ahb_xfer(1'b0, `IFSB_FLAGS_OFFSET, 32'h0, 5'h00);
        check_word(32'h0000_4066, rd);
        i_reset_n <= 1'b0;
        @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        check_word(32'h0, {16'h0, flags});
        check_word(32'h0, hrdata);
        ahb_xfer(1'b0, `IFSB_FLAGS_OFFSET, 32'h0, 5'h00);
        check_word(32'h0, rd);
        stop_test();
    end
endmodule : ifsb_bank_tb

// ==== verif/ifsb_src_model.sv ====
// Request source model for the flag bank: stands in for the clock/calendar, the external lines and the I2C port.
// Assumes the bench names the sources to fire one cycle before their request should reach the bank.
`timescale 1ns/1ps

module ifsb_src_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [4:0] i_fire,
    output logic o_rtcc_req,
    output logic o_ext_line4_req,
    output logic o_ext_line3_req,
    output logic o_i2c_port2_master_req,
    output logic o_i2c_port2_slave_req
);
    logic [4:0] req_q;

    // Requests leave a flop on i_clk, as real peripherals would, so they never change near the sampling edge.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            req_q <= 5'h00;
        else
            req_q <= i_fire;
    end

    assign {o_rtcc_req, o_ext_line4_req, o_ext_line3_req, o_i2c_port2_master_req, o_i2c_port2_slave_req} = req_q;
endmodule : ifsb_src_model
